// *** verilog/temp_sensor_pkg.sv ***
`default_nettype none

package temp_sensor_pkg;

  // register pointer values
  localparam logic [7:0]  ADDR_RESULT     = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h01;
  localparam logic [7:0]  ADDR_LOW        = 8'h02;
  localparam logic [7:0]  ADDR_HIGH       = 8'h03;

  // reset values
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [15:0] CONTROL_RESET   = 16'h00FF;
  localparam logic [15:0] LOW_RESET       = 16'h4B00;
  localparam logic [15:0] HIGH_RESET      = 16'h5000;

  // operating_control field positions
  localparam int          ONE_SHOT_BIT    = 15;
  localparam int          RATE_LSB        = 13;
  localparam int          FAULT_LSB       = 11;
  localparam int          POLARITY_BIT    = 10;
  localparam int          MODE_BIT        = 9;
  localparam int          PDOWN_BIT       = 8;

  // temperature field of result and thresholds
  localparam int          TEMP_LSB        = 4;
  localparam int          TEMP_W          = 12;

  // shortest conversion period, 27.5 ms, kept in microseconds
  localparam int          CONV_PERIOD_US  = 27500;
  localparam int          CLK_FREQ_MHZ    = 10;
  localparam int          CONV_BASE_CYCLES = CONV_PERIOD_US * CLK_FREQ_MHZ;

  // byte-level requests from the two-wire target engine
  typedef struct packed {
    logic       ptr_wr;
    logic       wr;
    logic       rd;
    logic       stop;
    logic [7:0] data;
  } byte_req_type;

  // read byte handed back to the engine
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_rsp_type;

  // byte phase within one transfer
  typedef enum {
    XFER_IDLE,
    WR_MSB_HELD,
    WR_DONE,
    RD_MSB_SENT,
    RD_LSB_SENT
  } xfer_state_type;

endpackage : temp_sensor_pkg

`default_nettype wire

// *** verilog/conv_scheduler.sv ***
`timescale 1ns/1ps
`default_nettype none

module conv_scheduler
  import temp_sensor_pkg::*;
#(
  parameter int BASE_CYCLES = CONV_BASE_CYCLES
)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // controls
  input  wire logic [1:0] rate_sel,
  input  wire logic       power_down,
  input  wire logic       one_shot,
  // converter start
  output logic            conv_request
);

  localparam int CW = $clog2(BASE_CYCLES * 8 + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] period_m1;
  logic          fire;
  logic [CW-1:0] next_count;

  // slowest rate is eight base periods; a rate change lands at the next reload
  assign period_m1  = (CW'(BASE_CYCLES) << rate_sel) - CW'(1);
  assign fire       = one_shot | (~power_down & (count == '0));
  // held at zero in shutdown so leaving it converts at once
  assign next_count = power_down ? '0 : (fire ? period_m1 : count - CW'(1));

  // period counter and start pulse
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count        <= '0;
      conv_request <= 1'b0;
    end
    else
    begin
      count        <= next_count;
      conv_request <= fire;
    end
  end

endmodule : conv_scheduler

`default_nettype wire

// *** verilog/temp_sensor_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_register_bank
  import temp_sensor_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_BASE_CYCLES
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // byte interface from the two-wire target engine
  input  wire byte_req_type      bus_req,
  output byte_rsp_type           bus_rsp,
  // successful alert response seen by the engine
  input  wire logic              alert_resp_ok,
  // converter
  output logic                   conv_request,
  input  wire logic              conv_done,
  input  wire logic [TEMP_W-1:0] conv_result,
  // alert pin
  output logic                   over_temp_flag_pin
);

  // signed compare of two temperature fields
  function automatic logic temp_ge(input logic [TEMP_W-1:0] a, input logic [TEMP_W-1:0] b);
    temp_ge = $signed(a) >= $signed(b);
  endfunction : temp_ge

  // temperature field of a 16-bit register
  function automatic logic [TEMP_W-1:0] temp_field(input logic [15:0] w);
    temp_field = w[15:TEMP_LSB];
  endfunction : temp_field

  logic [15:0]    temperature_result;
  logic [15:0]    operating_control;
  logic [15:0]    alert_low_threshold;
  logic [15:0]    alert_high_threshold;
  logic [7:0]     pointer;
  logic [7:0]     msb_hold;
  logic [15:0]    read_snap;
  xfer_state_type xfer_state;
  logic           alert_active;
  logic           watch_low;
  logic [1:0]     fault_cnt;

  // control fields
  wire logic [1:0] rate_sel   = operating_control[RATE_LSB+1:RATE_LSB];
  wire logic [1:0] fault_sel  = operating_control[FAULT_LSB+1:FAULT_LSB];
  wire logic       alert_polarity = operating_control[POLARITY_BIT];
  wire logic       int_mode   = operating_control[MODE_BIT];
  wire logic       power_down = operating_control[PDOWN_BIT];

  // write commit: on the second byte, or at stop with one byte held
  wire logic        commit_now  = (xfer_state == WR_MSB_HELD) && (bus_req.wr || bus_req.stop);
  wire logic        commit_full = bus_req.wr;
  wire logic [15:0] commit_word = {msb_hold, commit_full ? bus_req.data : 8'h00};
  wire logic        ctl_commit  = commit_now && (pointer == ADDR_CONTROL);
  wire logic        low_commit  = commit_now && (pointer == ADDR_LOW);
  wire logic        high_commit = commit_now && (pointer == ADDR_HIGH);
  wire logic        one_shot    = ctl_commit && commit_word[ONE_SHOT_BIT];
  wire logic        shutdown_cmd = ctl_commit && commit_word[PDOWN_BIT];

  // one-shot is never stored, so it always reads back zero
  wire logic [15:0] next_control = commit_full
                                 ? {1'b0, commit_word[14:0]}
                                 : {1'b0, commit_word[14:8], operating_control[7:0]};
  // low nibble of a threshold is forced to zero; one byte keeps the old bits 7:4
  wire logic [15:0] next_low  = {commit_word[15:8],
                                 commit_full ? commit_word[7:4] : alert_low_threshold[7:4],
                                 4'h0};
  wire logic [15:0] next_high = {commit_word[15:8],
                                 commit_full ? commit_word[7:4] : alert_high_threshold[7:4],
                                 4'h0};

  // read side: snapshot at the high byte keeps both bytes of one word coherent
  wire logic        read_first = (xfer_state != RD_MSB_SENT);
  wire logic        reg_read_event = bus_req.rd && read_first;
  wire logic [15:0] read_word =
      (pointer == ADDR_RESULT)  ? temperature_result :
      (pointer == ADDR_CONTROL) ? operating_control :
      (pointer == ADDR_LOW)     ? alert_low_threshold :
      (pointer == ADDR_HIGH)    ? alert_high_threshold : 16'h0000;
  wire logic [7:0]  next_rd_data = read_first ? read_word[15:8] : read_snap[7:0];

  // byte phase sequencing
  xfer_state_type next_xfer;
  always_comb
  begin
    next_xfer = xfer_state;
    if (bus_req.ptr_wr || bus_req.stop)
      next_xfer = XFER_IDLE;
    else if (bus_req.wr)
    begin
      unique case (xfer_state)
        XFER_IDLE:   next_xfer = WR_MSB_HELD;
        WR_MSB_HELD: next_xfer = WR_DONE;
        WR_DONE:     next_xfer = WR_DONE;
        RD_MSB_SENT: next_xfer = WR_DONE;
        RD_LSB_SENT: next_xfer = WR_DONE;
      endcase
    end
    else if (bus_req.rd)
      next_xfer = (xfer_state == RD_MSB_SENT) ? RD_LSB_SENT : RD_MSB_SENT;
  end

  // transfer state, pointer and read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      xfer_state <= XFER_IDLE;
      pointer    <= ADDR_RESULT;
      msb_hold   <= 8'h00;
      read_snap  <= 16'h0000;
      bus_rsp    <= '0;
    end
    else
    begin
      xfer_state    <= next_xfer;
      bus_rsp.valid <= bus_req.rd;
      if (bus_req.ptr_wr)
        pointer <= bus_req.data;
      if (bus_req.wr && (xfer_state == XFER_IDLE))
        msb_hold <= bus_req.data;
      if (reg_read_event)
        read_snap <= read_word;
      if (bus_req.rd)
        bus_rsp.data <= next_rd_data;
    end
  end

  // writable registers; the result pointer takes no write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      operating_control    <= CONTROL_RESET;
      alert_low_threshold  <= LOW_RESET;
      alert_high_threshold <= HIGH_RESET;
    end
    else
    begin
      if (ctl_commit)
        operating_control <= next_control;
      if (low_commit)
        alert_low_threshold <= next_low;
      if (high_commit)
        alert_high_threshold <= next_high;
    end
  end

  // result register, zero until the first conversion lands
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      temperature_result <= RESULT_RESET;
    else if (conv_done)
      temperature_result <= {conv_result, 4'h0};
  end

  // interrupt clear first, then a same-cycle conversion counts against the new target
  wire logic       clear_evt = int_mode && alert_active &&
                               (reg_read_event || alert_resp_ok || shutdown_cmd);
  wire logic       a_act     = clear_evt ? 1'b0 : alert_active;
  wire logic       a_watch   = clear_evt ? ~watch_low : watch_low;
  wire logic [1:0] a_cnt     = clear_evt ? 2'b00 : fault_cnt;

  // comparator looks for recovery while active, interrupt follows its own target
  wire logic [TEMP_W-1:0] new_temp = conv_result;
  wire logic       at_high   = temp_ge(new_temp, temp_field(alert_high_threshold));
  wire logic       below_low = ~temp_ge(new_temp, temp_field(alert_low_threshold));
  wire logic       look_low  = int_mode ? a_watch : a_act;
  wire logic       hit       = look_low ? below_low : at_high;
  wire logic       reached   = (a_cnt == fault_sel);
  wire logic       frozen    = int_mode && a_act;

  logic       next_active;
  logic       next_watch;
  logic [1:0] next_cnt;
  always_comb
  begin
    next_active = a_act;
    next_watch  = a_watch;
    next_cnt    = a_cnt;
    if (ctl_commit)
    begin
      next_active = 1'b0;
      next_watch  = 1'b0;
      next_cnt    = 2'b00;
    end
    else if (conv_done && !frozen)
    begin
      if (!hit)
        next_cnt = 2'b00;
      else if (reached)
      begin
        next_active = int_mode ? 1'b1 : ~a_act;
        next_cnt    = 2'b00;
      end
      else
        next_cnt = a_cnt + 2'b01;
    end
  end

  // alert state and pin; a one-cycle lag on the pin buys a glitch-free output
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alert_active       <= 1'b0;
      watch_low          <= 1'b0;
      fault_cnt          <= 2'b00;
      over_temp_flag_pin <= 1'b1;
    end
    else
    begin
      alert_active       <= next_active;
      watch_low          <= next_watch;
      fault_cnt          <= next_cnt;
      over_temp_flag_pin <= alert_polarity ? alert_active : ~alert_active;
    end
  end

  // conversion timing
  conv_scheduler #(
    .BASE_CYCLES (CONV_CYCLES)
  ) u_sched (
    .clk          (clk),
    .nrst         (nrst),
    .rate_sel     (rate_sel),
    .power_down   (power_down),
    .one_shot     (one_shot),
    .conv_request (conv_request)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_result_low_zero: assert property (temperature_result[3:0] == 4'h0)
    else $error("result low nibble not zero");

  a_result_hold: assert property (!conv_done |=> $stable(temperature_result))
    else $error("result changed without a conversion");

  a_result_load: assert property (conv_done |=>
      temperature_result == {$past(conv_result), 4'h0})
    else $error("result not loaded from conversion");

  a_short_read_ok: assert property ((xfer_state == RD_MSB_SENT) && bus_req.stop
      && !conv_done |=> (xfer_state == XFER_IDLE) && $stable(operating_control)
      && $stable(temperature_result))
    else $error("short read disturbed state");

  a_one_shot_start: assert property (one_shot |=> conv_request
      && !operating_control[ONE_SHOT_BIT])
    else $error("one-shot did not start or read back nonzero");

  a_single_wr_keep: assert property (ctl_commit && !bus_req.wr |=>
      operating_control[7:0] == $past(operating_control[7:0]))
    else $error("single byte write touched low byte");

  a_pin_polarity: assert property (1'b1 |=> over_temp_flag_pin ==
      ($past(alert_polarity) ? $past(alert_active) : !$past(alert_active)))
    else $error("alert pin polarity wrong");

  a_mode_wr_clear: assert property (ctl_commit |=> !alert_active
      && (fault_cnt == 2'b00) && !watch_low)
    else $error("control write did not clear alert state");

  a_int_read_clear: assert property (int_mode && alert_active && reg_read_event
      && !conv_done && !ctl_commit |=> !alert_active && (watch_low != $past(watch_low)))
    else $error("interrupt alert not cleared by read");

  a_result_ro: assert property (commit_now && (pointer == ADDR_RESULT) && !conv_done
      |=> $stable(temperature_result))
    else $error("write reached result register");

  a_queue_depth: assert property (conv_done && !ctl_commit && !int_mode && hit
      && (fault_cnt != fault_sel) |=> (alert_active == $past(alert_active)))
    else $error("alert changed before queue filled");

  a_read_answer: assert property (bus_req.rd |=> bus_rsp.valid)
    else $error("read byte not answered");

  a_ctl_word_write: assert property (ctl_commit && bus_req.wr |=>
      operating_control == {1'b0, $past(msb_hold[6:0]), $past(bus_req.data)})
    else $error("word write to control landed wrong");

  a_ctl_byte_read: assert property (bus_req.rd && read_first &&
      (pointer == ADDR_CONTROL) |=> bus_rsp.data == $past(operating_control[15:8]))
    else $error("control read did not return the high byte");

  a_low_decode: assert property (bus_req.rd && read_first &&
      (pointer == ADDR_LOW) |=> bus_rsp.data == $past(alert_low_threshold[15:8]))
    else $error("low threshold pointer decoded wrong");

  a_high_decode: assert property (bus_req.rd && read_first &&
      (pointer == ADDR_HIGH) |=> bus_rsp.data == $past(alert_high_threshold[15:8]))
    else $error("high threshold pointer decoded wrong");

  a_thresh_nibble: assert property ((alert_low_threshold[3:0] == 4'h0)
      && (alert_high_threshold[3:0] == 4'h0))
    else $error("threshold low nibble not zero");

  a_comp_set: assert property (conv_done && !ctl_commit && !int_mode && !alert_active
      && (fault_cnt == fault_sel)
      && temp_ge(conv_result, temp_field(alert_high_threshold)) |=> alert_active)
    else $error("comparator alert did not set at the high threshold");

  a_comp_clear: assert property (conv_done && !ctl_commit && !int_mode && alert_active
      && (fault_cnt == fault_sel)
      && !temp_ge(conv_result, temp_field(alert_low_threshold)) |=> !alert_active)
    else $error("comparator alert did not clear below the low threshold");

  a_int_hold: assert property (int_mode && alert_active && !reg_read_event
      && !alert_resp_ok && !ctl_commit |=> alert_active)
    else $error("interrupt alert dropped without a clearing event");

  a_resp_clear: assert property (int_mode && alert_active && alert_resp_ok
      && !conv_done && !ctl_commit |=> !alert_active)
    else $error("alert response did not clear the interrupt alert");

  a_shutdown_idle: assert property (power_down && !one_shot |=> !conv_request)
    else $error("conversion started in shutdown");

endmodule : temp_sensor_register_bank

`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_model
  import temp_sensor_pkg::*;
(
  // clock
  input  wire logic         clk,
  // byte interface toward the register bank
  output var byte_req_type  bus_req,
  input  wire byte_rsp_type bus_rsp
);
  initial bus_req = '0;

  // kind: 8 pointer, 4 write, 2 read, 1 stop; held across exactly one edge
  task automatic send(input logic [3:0] kind, input logic [7:0] data);
    @(posedge clk);
    #1 bus_req = {kind, data};
    @(posedge clk);
    #1 bus_req = '0;
  endtask : send

  // high byte goes first, low byte only for a word write
  task automatic write(input logic [7:0] ptr, input logic [15:0] d, input int n);
    send(4'h8, ptr);
    send(4'h4, d[15:8]);
    if (n == 2) send(4'h4, d[7:0]);
    send(4'h1, 8'h00);
  endtask : write

  // a missing answer leaves unknown bits so no compare can pass
  task automatic get(input int n, output logic [15:0] d);
    d = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      send(4'h2, 8'h00);
      d[15-8*i -: 8] = (bus_rsp.valid === 1'b1) ? bus_rsp.data : 8'hXX;
    end
    send(4'h1, 8'h00); // stopping after the high byte is allowed
  endtask : get

  task automatic read(input logic [7:0] ptr, input int n, output logic [15:0] d);
    send(4'h8, ptr);
    send(4'h1, 8'h00);
    get(n, d);
  endtask : read
endmodule : host_model

`default_nettype wire

// *** testbench/test_temp_sensor_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_temp_sensor_register_bank
  import temp_sensor_pkg::*;
();
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  byte_req_type      bus_req;
  byte_rsp_type      bus_rsp;
  logic              alert_resp_ok = 1'b0;
  logic              conv_request;
  logic              conv_done = 1'b0;
  logic [TEMP_W-1:0] temp = 12'h19A;
  logic              over_temp_flag_pin;
  logic [15:0]       d;
  int                fail_count = 0;
  int                checked = 0;
  int                req_count = 0;
  int                done_count = 0;
  int                cycles = 0;
  int                base;
  logic [15:0]       reset_tab [4] = '{16'h0000, 16'h00FF, 16'h4B00, 16'h5000};

  always #50 clk = ~clk;

  temp_sensor_register_bank #(.CONV_CYCLES(40)) temp_sensor_register_bank_inst (
    .clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .alert_resp_ok(alert_resp_ok), .conv_request(conv_request), .conv_done(conv_done),
    .conv_result(temp), .over_temp_flag_pin(over_temp_flag_pin));

  host_model host_model_inst (.clk(clk), .bus_req(bus_req), .bus_rsp(bus_rsp));

  // converter stand-in: answers each start ten cycles later
  always @(posedge clk)
  begin
    if (conv_request === 1'b1)
    begin
      req_count++;
      repeat (10) @(posedge clk);
      #1 conv_done = 1'b1;
      @(posedge clk);
      #1 conv_done = 1'b0;
      done_count++;
    end
  end

  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic pin_is(input logic lvl, input int lim);
    for (int i = 0; i < lim && over_temp_flag_pin !== lvl; i++)
    begin
      @(posedge clk);
      #1;
    end
    check({15'h0, over_temp_flag_pin}, {15'h0, lvl});
  endtask : pin_is

  task automatic wait_done(input int n);
    base = done_count;
    for (int i = 0; i < 3000 && done_count < base + n; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1;
  endtask : wait_done

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    host_model_inst.get(2, d);
    check(d, 16'h0000);
    for (int a = 1; a < 4; a++)
    begin
      host_model_inst.read(a[7:0], 2, d);
      check(d, reset_tab[a]);
    end
    $display("reset test done");

    wait_done(1);
    host_model_inst.read(8'h00, 2, d);
    check(d, 16'h19A0);
    host_model_inst.write(8'h00, 16'hFFFF, 2);
    host_model_inst.read(8'h00, 1, d);
    check(d, 16'h1900);
    host_model_inst.read(8'h00, 2, d);
    check(d, 16'h19A0);
    $display("result test done");

    host_model_inst.write(8'h01, 16'h7A34, 2);
    host_model_inst.read(8'h01, 2, d);
    check(d, 16'h7A34);
    host_model_inst.write(8'h01, 16'h0600, 1);
    host_model_inst.read(8'h01, 2, d);
    check(d, 16'h0634);
    host_model_inst.read(8'h01, 1, d);
    check(d, 16'h0600);
    host_model_inst.write(8'h01, 16'h0100, 2);
    repeat (60) @(posedge clk);
    base = req_count;
    #1 temp = 12'h1B2;
    host_model_inst.write(8'h01, 16'h8100, 2);
    host_model_inst.read(8'h01, 2, d);
    check(d, 16'h0100);
    repeat (200) @(posedge clk);
    check(16'(req_count - base), 16'h0001);
    host_model_inst.read(8'h00, 2, d);
    check(d, 16'h1B20);
    $display("control test done");

    for (int s = 0; s < 4; s++)
    begin
      host_model_inst.write(8'h01, {1'b0, s[1:0], 13'h0}, 2);
      base = req_count;
      repeat (800) @(posedge clk);
      base = req_count - base - 20 / (1 << s);
      check((base >= -1 && base <= 1) ? 16'h0001 : 16'h0000, 16'h0001);
    end
    $display("rate test done");

    host_model_inst.write(8'h02, 16'h123F, 2);
    host_model_inst.read(8'h02, 2, d);
    check(d, 16'h1230);
    host_model_inst.write(8'h03, 16'h5500, 1);
    host_model_inst.read(8'h03, 2, d);
    check(d, 16'h5500);
    $display("threshold test done");

    host_model_inst.write(8'h01, 16'h0000, 2);
    host_model_inst.write(8'h02, 16'h1000, 2);
    host_model_inst.write(8'h03, 16'h2000, 2);
    temp = 12'h250;
    pin_is(1'b0, 300);
    temp = 12'h050;
    pin_is(1'b1, 300);
    host_model_inst.write(8'h01, 16'h1C00, 2);
    pin_is(1'b0, 3);
    temp = 12'h250;
    wait_done(3);
    pin_is(1'b0, 0);
    wait_done(1);
    pin_is(1'b1, 0);
    $display("comparator test done");

    host_model_inst.write(8'h01, 16'h0200, 2);
    pin_is(1'b0, 300);
    host_model_inst.read(8'h00, 2, d);
    pin_is(1'b1, 3);
    wait_done(3);
    pin_is(1'b1, 0);
    temp = 12'h050;
    pin_is(1'b0, 300);
    @(posedge clk);
    #1 alert_resp_ok = 1'b1;
    @(posedge clk);
    #1 alert_resp_ok = 1'b0;
    pin_is(1'b1, 3);
    temp = 12'h250;
    pin_is(1'b0, 300);
    host_model_inst.write(8'h01, 16'h0300, 2);
    pin_is(1'b1, 3);
    $display("interrupt test done");
    final_report();
  end
endmodule : test_temp_sensor_register_bank

`default_nettype wire
